// ---- rtl/rtc_alarm_defs.vh ----
`ifndef RTC_ALARM_DEFS_VH
`define RTC_ALARM_DEFS_VH

// ==========================================================
// Register byte offsets (32-bit aligned words)
`define OFS_DATE_ALARM       8'h00
`define OFS_MONTH_ALARM      8'h04
`define OFS_FLAG_CONTROL_ONE 8'h08
`define OFS_IRQ_STATUS       8'h0c
`define OFS_IRQ_MASK         8'h10
`define OFS_LIVE_STATUS      8'h14

// ==========================================================
// Alarm register fields
`define ALARM_ENABLE_BIT     7
`define DATE_VALUE_WIDTH     6
`define MONTH_VALUE_WIDTH    5

// ==========================================================
// Flag control one fields
`define FC1_CARRY_FLAG_BIT   7
`define FC1_CARRY_IE_BIT     4
`define FC1_ALARM_IE_BIT     3
`define FC1_ALARM_FLAG_BIT   0

// ==========================================================
// Interrupt status and mask fields
`define IRQ_CARRY_BIT        0
`define IRQ_ALARM_BIT        1
`define IRQ_WIDTH            2

// ==========================================================
// Live status fields
`define LIVE_MATCH_BIT       0
`define LIVE_DATE_BIT        1
`define LIVE_MONTH_BIT       2

// ==========================================================
// Reset values
`define RST_ENABLE           1'b0
`define RST_CARRY_FLAG       1'b0
`define RST_CARRY_IE         1'b0
`define RST_ALARM_IE         1'b0
`define RST_ALARM_FLAG       1'b0
`define RST_IRQ_STATUS       2'h0
`define RST_IRQ_MASK         2'h0

`endif

// ---- rtl/bcd_field_match.v ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Compares one BCD alarm field against its counter
module bcd_field_match #(
  parameter WIDTH = 6
) (
  input  wire [7:0] alarm_i,
  input  wire [7:0] counter_i,
  output wire       enabled_o,
  output wire       match_o
);

  wire compare_enable;

  assign compare_enable = alarm_i[7];
  assign enabled_o      = compare_enable;
  // Enable bit kept out of the comparison
  assign match_o        = (alarm_i[WIDTH-1:0] == counter_i[WIDTH-1:0]);

endmodule // bcd_field_match

`default_nettype wire

// ---- rtl/irq_status.v ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Sticky event bits, write-one-to-clear, masked onto one line
module irq_status #(
  parameter WIDTH = 2
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] event_i,
  input  wire [WIDTH-1:0] clear_i,
  input  wire [WIDTH-1:0] mask_i,
  output wire [WIDTH-1:0] status_o,
  output wire             pending_o
);

  reg [WIDTH-1:0] status;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (rst_i) begin
          status[i] <= 1'b0;
        end else if (event_i[i]) begin
          // New event beats a simultaneous clear
          status[i] <= 1'b1;
        end else if (clear_i[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign status_o  = status;
  assign pending_o = |(status & mask_i);

endmodule // irq_status

`default_nettype wire

// ---- rtl/rtc_date_month_alarm.v ----
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_defs.vh"

// Functional notes
// - Date field compared when its enable set
// - Month field compared when its enable set
// - Alarm only when all enabled fields match
// - Power-on clears enables; manual reset keeps
// - Both resets clear interrupt enables and alarm flag
// - Carry flag set by carries, writes
// - Carry request equals flag and enable
// - Alarm request equals flag and enable
// - Match sets alarm flag; zero clears
// - Reserved bits read zero, written zero
module rtc_date_month_alarm (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        manual_reset_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  date_counter_i,
  input  wire [7:0]  month_counter_i,
  input  wire        other_fields_enabled_i,
  input  wire        other_fields_match_i,
  input  wire        seconds_carry_i,
  input  wire        sixty_four_hz_carry_i,
  input  wire        sixty_four_hz_read_i,
  output reg         carry_irq_o,
  output reg         alarm_irq_o,
  output reg         irq_o
);

  // ==========================================================
  // Register storage
  reg                            date_enable;
  reg [`DATE_VALUE_WIDTH-1:0]    date_value;
  reg                            month_enable;
  reg [`MONTH_VALUE_WIDTH-1:0]   month_value;
  reg                            carry_flag;
  reg                            carry_irq_enable;
  reg                            alarm_irq_enable;
  reg                            alarm_flag;
  reg [`IRQ_WIDTH-1:0]           irq_mask;
  reg                            match_prev;

  // ==========================================================
  // Bus decode
  wire                           bus_req;
  wire                           wr_byte0;
  wire                           wr_date;
  wire                           wr_month;
  wire                           wr_fc1;
  wire                           wr_status;
  wire                           wr_mask;
  wire [7:0]                     wdata;

  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_byte0  = bus_req & wb_we_i & wb_sel_i[0];
  assign wdata     = wb_dat_i[7:0];
  assign wr_date   = wr_byte0 & (wb_adr_i == `OFS_DATE_ALARM);
  assign wr_month  = wr_byte0 & (wb_adr_i == `OFS_MONTH_ALARM);
  assign wr_fc1    = wr_byte0 & (wb_adr_i == `OFS_FLAG_CONTROL_ONE);
  assign wr_status = wr_byte0 & (wb_adr_i == `OFS_IRQ_STATUS);
  assign wr_mask   = wr_byte0 & (wb_adr_i == `OFS_IRQ_MASK);

  // ==========================================================
  // Field comparison
  wire [7:0]                     date_alarm_word;
  wire [7:0]                     month_alarm_word;
  wire                           date_en_seen;
  wire                           date_hit;
  wire                           month_en_seen;
  wire                           month_hit;
  wire                           date_ok;
  wire                           month_ok;
  wire                           any_enabled;
  wire                           all_match;
  wire                           match_rise;

  assign date_alarm_word  = {date_enable, 1'b0, date_value};
  assign month_alarm_word = {month_enable, 2'b00, month_value};

  bcd_field_match #(
    .WIDTH     (`DATE_VALUE_WIDTH)
  ) u_date_match (
    .alarm_i   (date_alarm_word),
    .counter_i (date_counter_i),
    .enabled_o (date_en_seen),
    .match_o   (date_hit)
  );

  bcd_field_match #(
    .WIDTH     (`MONTH_VALUE_WIDTH)
  ) u_month_match (
    .alarm_i   (month_alarm_word),
    .counter_i (month_counter_i),
    .enabled_o (month_en_seen),
    .match_o   (month_hit)
  );

  assign date_ok    = ~date_en_seen | date_hit;
  assign month_ok   = ~month_en_seen | month_hit;
  // No enabled field at all would match forever; treat as no alarm
  assign any_enabled = date_en_seen | month_en_seen | other_fields_enabled_i;
  assign all_match  = any_enabled & date_ok & month_ok &
                      (~other_fields_enabled_i | other_fields_match_i);
  // Edge of the match, so a flag cleared inside the matching second stays clear
  assign match_rise = all_match & ~match_prev;

  always @(posedge clk_i) begin
    if (rst_i) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= all_match;
    end
  end

  // ==========================================================
  // Alarm registers: only the enables see power-on reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      date_enable  <= `RST_ENABLE;
      month_enable <= `RST_ENABLE;
    end else begin
      if (wr_date) begin
        date_enable <= wdata[`ALARM_ENABLE_BIT];
      end
      if (wr_month) begin
        month_enable <= wdata[`ALARM_ENABLE_BIT];
      end
    end
  end

  // Value bits hold through every reset; a manual reset leaves all alone
  always @(posedge clk_i) begin
    if (wr_date && !rst_i) begin
      date_value <= wdata[`DATE_VALUE_WIDTH-1:0];
    end
    if (wr_month && !rst_i) begin
      month_value <= wdata[`MONTH_VALUE_WIDTH-1:0];
    end
  end

  // ==========================================================
  // Flag control one
  wire carry_event;

  assign carry_event = seconds_carry_i |
                       (sixty_four_hz_carry_i & sixty_four_hz_read_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      carry_flag <= `RST_CARRY_FLAG;
    end else if (carry_event) begin
      carry_flag <= 1'b1;
    end else if (wr_fc1) begin
      // Manual reset leaves the carry flag as it was
      carry_flag <= wdata[`FC1_CARRY_FLAG_BIT];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || manual_reset_i) begin
      carry_irq_enable <= `RST_CARRY_IE;
      alarm_irq_enable <= `RST_ALARM_IE;
    end else if (wr_fc1) begin
      carry_irq_enable <= wdata[`FC1_CARRY_IE_BIT];
      alarm_irq_enable <= wdata[`FC1_ALARM_IE_BIT];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || manual_reset_i) begin
      alarm_flag <= `RST_ALARM_FLAG;
    end else if (match_rise) begin
      alarm_flag <= 1'b1;
    end else if (wr_fc1 && !wdata[`FC1_ALARM_FLAG_BIT]) begin
      alarm_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  wire [`IRQ_WIDTH-1:0] irq_events;
  wire [`IRQ_WIDTH-1:0] irq_clear;
  wire [`IRQ_WIDTH-1:0] irq_stat;
  wire                  irq_pending;

  assign irq_events[`IRQ_CARRY_BIT] = carry_event;
  assign irq_events[`IRQ_ALARM_BIT] = match_rise;
  assign irq_clear = wr_status ? wdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

  irq_status #(
    .WIDTH     (`IRQ_WIDTH)
  ) u_irq_status (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .event_i   (irq_events),
    .clear_i   (irq_clear),
    .mask_i    (irq_mask),
    .status_o  (irq_stat),
    .pending_o (irq_pending)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= `RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask <= wdata[`IRQ_WIDTH-1:0];
    end
  end

  // ==========================================================
  // Request outputs, registered; one cycle behind the flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      carry_irq_o <= 1'b0;
      alarm_irq_o <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      carry_irq_o <= carry_flag & carry_irq_enable;
      alarm_irq_o <= alarm_flag & alarm_irq_enable;
      irq_o       <= irq_pending;
    end
  end

  // ==========================================================
  // Read mux
  reg [7:0] rdata;

  always @* begin
    rdata = 8'h00;
    case (wb_adr_i)
      `OFS_DATE_ALARM: begin
        rdata = {date_enable, 1'b0, date_value};
      end
      `OFS_MONTH_ALARM: begin
        rdata = {month_enable, 2'b00, month_value};
      end
      `OFS_FLAG_CONTROL_ONE: begin
        // Reserved positions 6, 5, 2, 1 forced to zero
        rdata[`FC1_CARRY_FLAG_BIT] = carry_flag;
        rdata[`FC1_CARRY_IE_BIT]   = carry_irq_enable;
        rdata[`FC1_ALARM_IE_BIT]   = alarm_irq_enable;
        rdata[`FC1_ALARM_FLAG_BIT] = alarm_flag;
      end
      `OFS_IRQ_STATUS: begin
        rdata[`IRQ_WIDTH-1:0] = irq_stat;
      end
      `OFS_IRQ_MASK: begin
        rdata[`IRQ_WIDTH-1:0] = irq_mask;
      end
      `OFS_LIVE_STATUS: begin
        rdata[`LIVE_MATCH_BIT] = all_match;
        rdata[`LIVE_DATE_BIT]  = date_en_seen & date_hit;
        rdata[`LIVE_MONTH_BIT] = month_en_seen & month_hit;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // Wishbone answer: one wait state, ack held a single cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= {24'h00_0000, rdata};
      end
    end
  end

endmodule // rtc_date_month_alarm

`default_nettype wire

// ---- dv/rtc_alarm_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_defs.vh"

// ====================
// Bus, flag and interrupt timing checks
module rtc_alarm_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        manual_reset_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        seconds_carry_i,
  input wire logic        sixty_four_hz_carry_i,
  input wire logic        sixty_four_hz_read_i,
  input wire logic        carry_irq_o,
  input wire logic        alarm_irq_o,
  input wire logic        irq_o
);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd = wb_ack_o && !wb_we_i;
  wire wr_ctl = req && wb_we_i && wb_adr_i == `OFS_FLAG_CONTROL_ONE;
  wire carry_ev = seconds_carry_i || (sixty_four_hz_carry_i && sixty_four_hz_read_i);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_follows: assert property (req |=> wb_ack_o)
    else $error("request not acked");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ctl_rsv: assert property (rd && wb_adr_i == `OFS_FLAG_CONTROL_ONE |->
    wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:5] == 2'h0 && wb_dat_o[2:1] == 2'h0)
    else $error("reserved control bits not zero");
  a_alarm_rsv: assert property (rd |-> !(wb_adr_i == `OFS_DATE_ALARM && wb_dat_o[6]) &&
    !(wb_adr_i == `OFS_MONTH_ALARM && wb_dat_o[6:5] != 2'h0))
    else $error("alarm reserved bits not zero");
  a_carry_rise: assert property ($rose(carry_irq_o) |-> $past(carry_ev || wr_ctl, 2))
    else $error("carry request without cause");
  a_carry_fall: assert property ($fell(carry_irq_o) |-> $past(wr_ctl || manual_reset_i, 2))
    else $error("carry request dropped alone");
  a_alarm_hold: assert property ($fell(alarm_irq_o) |-> $past(wr_ctl || manual_reset_i, 2))
    else $error("alarm request dropped alone");
  a_manual_quiet: assert property (manual_reset_i |-> ##2 !carry_irq_o && !alarm_irq_o)
    else $error("request after manual reset");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !carry_irq_o && !alarm_irq_o && !irq_o)
    else $error("outputs active after reset");

  c_carry: cover property ($rose(carry_irq_o));
  c_alarm: cover property ($rose(alarm_irq_o));
  c_irq: cover property ($rose(irq_o));
endmodule // rtc_alarm_checker

bind rtc_date_month_alarm rtc_alarm_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .manual_reset_i(manual_reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .seconds_carry_i(seconds_carry_i), .sixty_four_hz_carry_i(sixty_four_hz_carry_i),
  .sixty_four_hz_read_i(sixty_four_hz_read_i), .carry_irq_o(carry_irq_o),
  .alarm_irq_o(alarm_irq_o), .irq_o(irq_o));
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_defs.vh"

module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        manual_reset_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [7:0]  date_counter_i = 8'h14;
  logic [7:0]  month_counter_i = 8'h06;
  logic        other_fields_enabled_i = 1'b0;
  logic        other_fields_match_i = 1'b0;
  logic        seconds_carry_i = 1'b0;
  logic        sixty_four_hz_carry_i = 1'b0;
  logic        sixty_four_hz_read_i = 1'b0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, carry_irq_o, alarm_irq_o, irq_o;
  int          num_errors = 0;
  int          n_tests = 0;
  localparam   CTL = `OFS_FLAG_CONTROL_ONE;
  localparam   SEC = 0;
  localparam   RD64 = 1;
  localparam   MRST = 2;

  rtc_date_month_alarm DUT (.clk_i(clk_i), .rst_i(rst_i), .manual_reset_i(manual_reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .date_counter_i(date_counter_i), .month_counter_i(month_counter_i),
    .other_fields_enabled_i(other_fields_enabled_i),
    .other_fields_match_i(other_fields_match_i), .seconds_carry_i(seconds_carry_i),
    .sixty_four_hz_carry_i(sixty_four_hz_carry_i), .sixty_four_hz_read_i(sixty_four_hz_read_i),
    .carry_irq_o(carry_irq_o), .alarm_irq_o(alarm_irq_o), .irq_o(irq_o));

  initial forever #10 clk_i = ~clk_i;

  // ====================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Master waits on ack only; the watchdog bounds a hang
  task automatic acc(input logic [7:0] a, input logic we, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    acc(a, 1'b0, 8'h00, q);
    chk(nm, q, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic set_cnt(input logic [7:0] dt, input logic [7:0] mo);
    @(posedge clk_i);
    date_counter_i  <= dt;
    month_counter_i <= mo;
    tick(3);
  endtask

  // One-cycle pulse on a chosen event input, raised and dropped on rising edges
  task automatic pulse(input int sel);
    @(posedge clk_i);
    if (sel == SEC) begin
      seconds_carry_i <= 1'b1;
    end else if (sel == RD64) begin
      sixty_four_hz_read_i <= 1'b1;
    end else begin
      manual_reset_i <= 1'b1;
    end
    @(posedge clk_i);
    seconds_carry_i      <= 1'b0;
    sixty_four_hz_read_i <= 1'b0;
    manual_reset_i       <= 1'b0;
    tick(2);
  endtask

  // ====================
  // Scenarios
  task automatic t_reset;
    logic [7:0] q;
    rd(CTL, 8'h00, "ctl");
    acc(`OFS_DATE_ALARM, 1'b0, 8'h00, q);
    chk("date en", q[7], 1'b0);
    acc(`OFS_MONTH_ALARM, 1'b0, 8'h00, q);
    chk("month en", q[7], 1'b0);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00, "unmapped");
    $display("reset test done");
  endtask

  task automatic t_carry;
    wr(CTL, 8'h10);
    pulse(SEC);
    chk("cirq", carry_irq_o, 1'b1);
    rd(CTL, 8'h90, "sec carry");
    wr(CTL, 8'h10);
    tick(2);
    chk("cirq clr", carry_irq_o, 1'b0);
    @(posedge clk_i);
    sixty_four_hz_carry_i <= 1'b1;
    tick(3);
    rd(CTL, 8'h10, "64 no read");
    pulse(RD64);
    @(posedge clk_i);
    sixty_four_hz_carry_i <= 1'b0;
    rd(CTL, 8'h90, "64 read");
    // Carry pulse lands on the very edge that takes the clearing write
    fork
      wr(CTL, 8'h10);
      pulse(SEC);
    join
    rd(CTL, 8'h90, "set wins");
    wr(CTL, 8'h80);
    rd(CTL, 8'h80, "rsv");
    tick(2);
    chk("cirq off", carry_irq_o, 1'b0);
    $display("carry test done");
  endtask

  task automatic t_alarm;
    wr(CTL, 8'h08);
    wr(`OFS_DATE_ALARM, 8'h95);
    wr(`OFS_MONTH_ALARM, 8'h87);
    set_cnt(8'h14, 8'h07);
    rd(CTL, 8'h08, "date miss");
    set_cnt(8'h15, 8'h06);
    rd(CTL, 8'h08, "month miss");
    set_cnt(8'h15, 8'h07);
    chk("airq", alarm_irq_o, 1'b1);
    rd(CTL, 8'h09, "match");
    set_cnt(8'h16, 8'h07);
    rd(CTL, 8'h09, "sticky");
    wr(CTL, 8'h01);
    tick(2);
    chk("airq off", alarm_irq_o, 1'b0);
    wr(CTL, 8'h08);
    rd(CTL, 8'h08, "af clr");
    wr(`OFS_MONTH_ALARM, 8'h03);
    set_cnt(8'h15, 8'h07);
    rd(CTL, 8'h09, "month off");
    wr(CTL, 8'h08);
    other_fields_enabled_i <= 1'b1;
    set_cnt(8'h16, 8'h07);
    set_cnt(8'h15, 8'h07);
    rd(CTL, 8'h08, "others miss");
    other_fields_match_i <= 1'b1;
    tick(3);
    rd(CTL, 8'h09, "others hit");
    rd(`OFS_LIVE_STATUS, 8'h03, "live");
    $display("alarm test done");
  endtask

  task automatic t_manual;
    wr(CTL, 8'h99);
    pulse(MRST);
    rd(CTL, 8'h80, "manual");
    rd(`OFS_DATE_ALARM, 8'h95, "date kept");
    rd(`OFS_MONTH_ALARM, 8'h03, "month kept");
    $display("manual test done");
  endtask

  task automatic t_irq;
    wr(`OFS_IRQ_STATUS, 8'h03);
    wr(`OFS_IRQ_MASK, 8'h01);
    pulse(SEC);
    chk("irq", irq_o, 1'b1);
    wr(`OFS_IRQ_STATUS, 8'h01);
    tick(2);
    chk("irq w1c", irq_o, 1'b0);
    wr(`OFS_IRQ_MASK, 8'h00);
    pulse(SEC);
    chk("irq mask", irq_o, 1'b0);
    rd(`OFS_IRQ_STATUS, 8'h01, "status");
    $display("irq test done");
  endtask

  // Mid-run power-on reset; other fields dropped so no match greets the release
  task automatic t_por;
    logic [7:0] q;
    @(posedge clk_i);
    rst_i                  <= 1'b1;
    other_fields_enabled_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(`OFS_DATE_ALARM, 1'b0, 8'h00, q);
    chk("por date en", q[7], 1'b0);
    rd(CTL, 8'h00, "por ctl");
    rd(`OFS_IRQ_STATUS, 8'h00, "por status");
    $display("power-on test done");
  endtask

  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_carry;
    t_alarm;
    t_manual;
    t_irq;
    t_por;
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
